/* shared/temp_alarm_pkg.sv */
// Constants shared by the temperature limit alarm block
package temp_alarm_pkg;
  // Clock and timing, times in their own units
  localparam int CLK_PERIOD_NS = 8;
  localparam int PASS_PERIOD_MS = 480;
  localparam int CONV_DELAY_MS = 60;
  localparam int BUS_TIMEOUT_MIN_MS = 25;
  localparam int BUS_TIMEOUT_MAX_MS = 40;
  localparam int NS_PER_MS = 1000000;
  // Two channels share one pass, so each slot is half of it
  localparam int SLOT_CYC = PASS_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS / 2;
  localparam int CONV_DELAY_CYC = CONV_DELAY_MS * NS_PER_MS / CLK_PERIOD_NS;
  // Least timeout, rounded up to whole cycles
  localparam int BUS_TIMEOUT_CYC =
    (BUS_TIMEOUT_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [5:0] OFS_LOCAL_TEMP = 6'h00;
  localparam logic [5:0] OFS_REMOTE_TEMP = 6'h04;
  localparam logic [5:0] OFS_LOCAL_HIGH = 6'h08;
  localparam logic [5:0] OFS_REMOTE_HIGH = 6'h0c;
  localparam logic [5:0] OFS_CRIT = 6'h10;
  localparam logic [5:0] OFS_CONFIG = 6'h14;
  localparam logic [5:0] OFS_STATUS = 6'h18;
  localparam logic [5:0] OFS_IRQ_STATUS = 6'h1c;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h20;
  localparam logic [5:0] OFS_SERIAL = 6'h24;

  // Field positions
  localparam int CFG_ALERT_MASK_BIT = 7;
  localparam int CFG_ALERT_POL_BIT = 1;
  localparam int ST_LOCAL_HIGH_BIT = 0;
  localparam int ST_REMOTE_HIGH_BIT = 1;
  localparam int ST_LOCAL_CRIT_BIT = 2;
  localparam int ST_REMOTE_CRIT_BIT = 3;
  localparam int IRQ_CONV_BIT = 0;
  localparam int IRQ_TIMEOUT_BIT = 1;
  localparam int IRQ_CRIT_BIT = 2;
  localparam int IRQ_WIDTH = 3;
  localparam int SER_BUSY_BIT = 0;
  localparam int SER_TRIPPED_BIT = 1;

  // Reset values
  localparam logic [7:0] SETPOINT_RESET = 8'h7f;
  localparam logic [7:0] TEMP_RESET = 8'h00;

  // Channel codes and bus responses
  localparam logic CHAN_LOCAL = 1'b0;
  localparam logic CHAN_REMOTE = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* shared/conv_if.sv */
// Conversion result carrier between sequencer and alarm logic
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
  logic done;
  logic chan;
  logic [7:0] result;
  modport seq (output done, output chan, output result);
  modport alarm (input done, input chan, input result);
endinterface
`default_nettype wire

/* hdl/conv_sequencer.sv */
// Round-robin conversion sequencer: local slot, then remote slot
`timescale 1ns/1ps
`default_nettype none
module conv_sequencer
  import temp_alarm_pkg::*;
#(
  parameter int SLOT_CYCLES = SLOT_CYC,
  parameter int DELAY_CYCLES = CONV_DELAY_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] local_temp_reading,
  input wire logic [7:0] remote_temp_reading,
  conv_if.seq cv
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic chan;
  logic next_chan;
  logic [7:0] sample;
  logic [7:0] next_sample;
  logic done;
  logic next_done;

  // Sample at slot start, complete one delay later, then next channel
  always_comb begin
    next_cnt = cnt + 32'h1;
    next_chan = chan;
    next_sample = sample;
    next_done = 1'b0;
    if (cnt == 32'h0) begin
      next_sample = (chan == CHAN_REMOTE) ? remote_temp_reading : local_temp_reading;
    end
    if (cnt == 32'(DELAY_CYCLES - 1)) begin
      next_done = 1'b1;
    end
    if (cnt == 32'(SLOT_CYCLES - 1)) begin
      next_cnt = 32'h0;
      next_chan = ~chan;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= 32'h0;
      chan <= CHAN_LOCAL;
      sample <= TEMP_RESET;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      chan <= next_chan;
      sample <= next_sample;
      done <= next_done;
    end
  end

  assign cv.done = done;
  assign cv.chan = chan;
  assign cv.result = sample;
endmodule
`default_nettype wire

/* hdl/temp_limit_alarm_logic.sv */
// Temperature limit alarm logic with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module temp_limit_alarm_logic
  import temp_alarm_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYC,
  parameter int SLOT_CYCLES = SLOT_CYC,
  parameter int DELAY_CYCLES = CONV_DELAY_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] local_temp_reading,
  input wire logic [7:0] remote_temp_reading,
  input wire logic smb_clk_in,
  input wire logic smb_data_in,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic alert_out,
  output logic alert_oe,
  output logic critical_alarm_out,
  output logic critical_alarm_oe,
  output logic irq
);
  conv_if cv ();

  conv_sequencer #(
    .SLOT_CYCLES(SLOT_CYCLES),
    .DELAY_CYCLES(DELAY_CYCLES)
  ) u_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .local_temp_reading(local_temp_reading),
    .remote_temp_reading(remote_temp_reading),
    .cv(cv)
  );

  // Serial line synchronisers, stage one feeds stage two only
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_prev;
  logic sda_prev;
  logic serial_busy;
  logic next_serial_busy;
  logic tripped;
  logic next_tripped;
  logic [31:0] low_cnt;
  logic [31:0] next_low_cnt;
  logic timeout_ev;
  logic line_low;

  assign line_low = ~scl_sync[1] | ~sda_sync[1];

  // Start/stop tracking and stuck-low watchdog
  always_comb begin
    next_serial_busy = serial_busy;
    next_tripped = tripped;
    next_low_cnt = 32'h0;
    timeout_ev = 1'b0;
    if (scl_sync[1] && scl_prev && sda_prev && !sda_sync[1]) begin
      next_serial_busy = 1'b1;
    end
    if (scl_sync[1] && scl_prev && !sda_prev && sda_sync[1]) begin
      next_serial_busy = 1'b0;
    end
    if (!line_low) begin
      next_tripped = 1'b0;
    end else if (!tripped) begin
      next_low_cnt = low_cnt + 32'h1;
      if (low_cnt == 32'(TIMEOUT_CYCLES - 1)) begin
        // Abandon transfer; one event per stuck episode, not a stream
        timeout_ev = 1'b1;
        next_serial_busy = 1'b0;
        next_tripped = 1'b1;
        next_low_cnt = 32'h0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      serial_busy <= 1'b0;
      tripped <= 1'b0;
      low_cnt <= 32'h0;
    end else begin
      scl_sync <= {scl_sync[0], smb_clk_in};
      sda_sync <= {sda_sync[0], smb_data_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
      serial_busy <= next_serial_busy;
      tripped <= next_tripped;
      low_cnt <= next_low_cnt;
    end
  end

  // Register and alarm state
  logic [7:0] local_result, remote_result;
  logic [7:0] local_high_setpoint, remote_high_setpoint, critical_setpoint;
  logic alert_mask, alert_pol;
  logic [1:0] high_flag, crit_flag, high_hold, crit_hold, high_seen, crit_seen;
  logic [IRQ_WIDTH-1:0] irq_status, irq_mask;
  logic [7:0] next_local_result, next_remote_result;
  logic [7:0] next_local_high, next_remote_high, next_crit;
  logic next_alert_mask, next_alert_pol;
  logic [1:0] next_high_flag, next_crit_flag, next_high_hold, next_crit_hold;
  logic [1:0] next_high_seen, next_crit_seen;
  logic [IRQ_WIDTH-1:0] next_irq_status, next_irq_mask;
  // Bus slave state
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [5:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane, next_w_lane;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write, do_read, wr_ok, rd_ok, alert_active, next_alert_oe, next_crit_oe;
  logic [7:0] limit_high;
  logic [31:0] rd_word;
  logic [IRQ_WIDTH-1:0] irq_ev;

  // Read mux; unmapped offsets answer with an error and zero data
  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      OFS_LOCAL_TEMP: rd_word[7:0] = local_result;
      OFS_REMOTE_TEMP: rd_word[7:0] = remote_result;
      OFS_LOCAL_HIGH: rd_word[7:0] = local_high_setpoint;
      OFS_REMOTE_HIGH: rd_word[7:0] = remote_high_setpoint;
      OFS_CRIT: rd_word[7:0] = critical_setpoint;
      OFS_CONFIG: begin
        rd_word[CFG_ALERT_MASK_BIT] = alert_mask;
        rd_word[CFG_ALERT_POL_BIT] = alert_pol;
      end
      OFS_STATUS: begin
        rd_word[ST_LOCAL_HIGH_BIT] = high_flag[CHAN_LOCAL];
        rd_word[ST_REMOTE_HIGH_BIT] = high_flag[CHAN_REMOTE];
        rd_word[ST_LOCAL_CRIT_BIT] = crit_flag[CHAN_LOCAL];
        rd_word[ST_REMOTE_CRIT_BIT] = crit_flag[CHAN_REMOTE];
      end
      OFS_IRQ_STATUS: rd_word[IRQ_WIDTH-1:0] = irq_status;
      OFS_IRQ_MASK: rd_word[IRQ_WIDTH-1:0] = irq_mask;
      OFS_SERIAL: begin
        rd_word[SER_BUSY_BIT] = serial_busy;
        rd_word[SER_TRIPPED_BIT] = tripped;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // Bus handshakes, register writes, flag and alarm updates
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_local_result = local_result;
    next_remote_result = remote_result;
    next_local_high = local_high_setpoint;
    next_remote_high = remote_high_setpoint;
    next_crit = critical_setpoint;
    next_alert_mask = alert_mask;
    next_alert_pol = alert_pol;
    next_high_flag = high_flag;
    next_crit_flag = crit_flag;
    next_high_hold = high_hold;
    next_crit_hold = crit_hold;
    next_high_seen = high_seen;
    next_crit_seen = crit_seen;
    next_irq_mask = irq_mask;
    irq_ev = '0;
    wr_ok = 1'b1;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    do_write = aw_held && w_held && !s_axi_bvalid;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      unique case (aw_addr)
        OFS_LOCAL_HIGH: if (w_lane) next_local_high = w_byte;
        OFS_REMOTE_HIGH: if (w_lane) next_remote_high = w_byte;
        OFS_CRIT: if (w_lane) next_crit = w_byte;
        OFS_CONFIG: if (w_lane) begin
          next_alert_mask = w_byte[CFG_ALERT_MASK_BIT];
          next_alert_pol = w_byte[CFG_ALERT_POL_BIT];
        end
        OFS_IRQ_MASK: if (w_lane) next_irq_mask = w_byte[IRQ_WIDTH-1:0];
        OFS_LOCAL_TEMP, OFS_REMOTE_TEMP, OFS_STATUS, OFS_IRQ_STATUS, OFS_SERIAL: begin
        end
        default: wr_ok = 1'b0;
      endcase
      next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    do_read = s_axi_arvalid && s_axi_arready;
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == OFS_STATUS) begin
        // Read clears flags; held alarms wait for a quiet conversion
        next_high_flag = 2'b00;
        next_crit_flag = 2'b00;
        next_high_seen = high_seen | high_hold;
        next_crit_seen = crit_seen | crit_hold;
      end
    end
    // Completed conversion: signed compares, set beats read clear
    limit_high = (cv.chan == CHAN_REMOTE) ? remote_high_setpoint : local_high_setpoint;
    if (cv.done) begin
      irq_ev[IRQ_CONV_BIT] = 1'b1;
      if (cv.chan == CHAN_REMOTE) begin
        next_remote_result = cv.result;
      end else begin
        next_local_result = cv.result;
      end
      if ($signed(cv.result) > $signed(limit_high)) begin
        next_high_flag[cv.chan] = 1'b1;
        next_high_hold[cv.chan] = 1'b1;
        next_high_seen[cv.chan] = 1'b0;
      end else if (high_seen[cv.chan]) begin
        // Registered seen, so a read in this same cycle waits for a later result
        next_high_hold[cv.chan] = 1'b0;
        next_high_seen[cv.chan] = 1'b0;
      end
      if ($signed(cv.result) > $signed(critical_setpoint)) begin
        next_crit_flag[cv.chan] = 1'b1;
        next_crit_hold[cv.chan] = 1'b1;
        next_crit_seen[cv.chan] = 1'b0;
        irq_ev[IRQ_CRIT_BIT] = ~crit_hold[cv.chan];
      end else if (crit_seen[cv.chan]) begin
        next_crit_hold[cv.chan] = 1'b0;
        next_crit_seen[cv.chan] = 1'b0;
      end
    end
    irq_ev[IRQ_TIMEOUT_BIT] = timeout_ev;
    // Write-one-to-clear, but a same-cycle event still lands
    next_irq_status = irq_status;
    if (do_write && w_lane && aw_addr == OFS_IRQ_STATUS) begin
      next_irq_status = irq_status & ~w_byte[IRQ_WIDTH-1:0];
    end
    next_irq_status = next_irq_status | irq_ev;
    // Mask gates only the pin; flags keep working
    alert_active = |next_high_hold && !next_alert_mask;
    // Open drain: active low pulls when on, active high pulls when off
    next_alert_oe = next_alert_pol ? !alert_active : alert_active;
    next_crit_oe = |next_crit_hold;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 6'h00;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
      local_result <= TEMP_RESET;
      remote_result <= TEMP_RESET;
      local_high_setpoint <= SETPOINT_RESET;
      remote_high_setpoint <= SETPOINT_RESET;
      critical_setpoint <= SETPOINT_RESET;
      alert_mask <= 1'b0;
      alert_pol <= 1'b0;
      high_flag <= 2'b00;
      crit_flag <= 2'b00;
      high_hold <= 2'b00;
      crit_hold <= 2'b00;
      high_seen <= 2'b00;
      crit_seen <= 2'b00;
      irq_status <= '0;
      irq_mask <= '0;
      alert_out <= 1'b0;
      alert_oe <= 1'b0;
      critical_alarm_out <= 1'b0;
      critical_alarm_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane <= next_w_lane;
      // Ready only while the holding slot stays empty
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      local_result <= next_local_result;
      remote_result <= next_remote_result;
      local_high_setpoint <= next_local_high;
      remote_high_setpoint <= next_remote_high;
      critical_setpoint <= next_crit;
      alert_mask <= next_alert_mask;
      alert_pol <= next_alert_pol;
      high_flag <= next_high_flag;
      crit_flag <= next_crit_flag;
      high_hold <= next_high_hold;
      crit_hold <= next_crit_hold;
      high_seen <= next_high_seen;
      crit_seen <= next_crit_seen;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      alert_out <= 1'b0;
      alert_oe <= next_alert_oe;
      critical_alarm_out <= 1'b0;
      critical_alarm_oe <= next_crit_oe;
      irq <= |(next_irq_status & next_irq_mask);
    end
  end
endmodule
`default_nettype wire

/* tb/temp_alarm_monitor.sv */
// Port checker for the temperature limit alarm block
`timescale 1ns/1ps
`default_nettype none
module temp_alarm_monitor
  import temp_alarm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic alert_out,
  input wire logic critical_alarm_out,
  input wire logic critical_alarm_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic armed;
  logic next_armed;
  // Status read made while the alarm is held arms its release
  always_comb begin
    next_armed = armed;
    if (!critical_alarm_oe) begin
      next_armed = 1'b0;
    end
    if (critical_alarm_oe && s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_STATUS) begin
      next_armed = 1'b1;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
    end else begin
      armed <= next_armed;
    end
  end
  a_alert_drain_only: assert property (alert_out == 1'b0)
    else $error("alert pin driven high");
  a_crit_drain_only: assert property (critical_alarm_out == 1'b0)
    else $error("critical pin driven high");
  a_crit_release: assert property ($fell(critical_alarm_oe) |-> $past(armed))
    else $error("critical alarm released without status read");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_SERIAL
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read wrong");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_ready_wait: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  c_crit_release: cover property ($fell(critical_alarm_oe));
  c_bad_read: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_SERIAL);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind temp_limit_alarm_logic temp_alarm_monitor u_mon (
  .sys_clk, .rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .alert_out,
  .critical_alarm_out, .critical_alarm_oe
);
`default_nettype wire

/* tb/smb_host_model.sv */
// Serial host model driving the clock and data pins
`timescale 1ns/1ps
`default_nettype none
module smb_host_model (
  output logic scl,
  output logic sda
);
  // Released lines sit high on their pull-ups
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Start, then eight bits at a 64 ns clock; no stop, so the bus stays busy
  task automatic frame(input logic [7:0] b);
    #3 sda = 1'b0;
    #32;
    for (int i = 7; i >= 0; i--) begin
      scl = 1'b0;
      sda = b[i];
      #32 scl = 1'b1;
      #32;
    end
  endtask
  // Clock held low to stall the bus
  task automatic hold_low(input int ns);
    scl = 1'b0;
    #(ns);
  endtask
  // Stop returns both lines high
  task automatic idle();
    sda = 1'b0;
    #32 scl = 1'b1;
    #32 sda = 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the temperature limit alarm block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import temp_alarm_pkg::*;
;
  localparam int SLOT = 40;
  localparam int TMO = 40;
  logic sys_clk;
  logic rst = 1'b1;
  logic [7:0] local_temp_reading = 8'h00;
  logic [7:0] remote_temp_reading = 8'h00;
  wire logic smb_clk_in;
  wire logic smb_data_in;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic [5:0] s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic alert_out, alert_oe, critical_alarm_out, critical_alarm_oe, irq;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int st = 0;
  bit hl, hr, cl, cr, al, ar, acl, acr;
  logic [31:0] seed = 32'h45;
  // Columns: local, remote, local high, remote high, critical, config
  logic [7:0] tv [5][6] = '{'{8'h20, 8'h05, 8'h10, 8'h10, 8'h7f, 8'h00},
    '{8'h20, 8'h05, 8'h10, 8'h10, 8'h7f, 8'h02}, '{8'hf0, 8'h30, 8'h05, 8'h30, 8'h18, 8'h00},
    '{8'h00, 8'h00, 8'h10, 8'h30, 8'h18, 8'h00}, '{8'h40, 8'h00, 8'h10, 8'h30, 8'h18, 8'h80}};

  temp_limit_alarm_logic #(.TIMEOUT_CYCLES(TMO), .SLOT_CYCLES(SLOT), .DELAY_CYCLES(10)) u_dut (
    .sys_clk, .rst, .local_temp_reading, .remote_temp_reading, .smb_clk_in, .smb_data_in,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .alert_out, .alert_oe, .critical_alarm_out, .critical_alarm_oe, .irq);
  smb_host_model u_host (.scl(smb_clk_in), .sda(smb_data_in));

  // Clock, and a cycle count that gives the conversion phase
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= rst ? 0 : cyc + 1;

  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bus master: hold each channel until taken, wait for the answer
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bit aw, w;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Keeps bus traffic clear of the moments when results land
  task automatic sync(input int p);
    while (cyc % SLOT != p) @(posedge sys_clk);
  endtask
  // Model of one comparator with its sticky hold
  task automatic upd(input logic [7:0] v, s, inout bit h, a, input int b);
    if ($signed(v) > $signed(s)) begin
      h = 1'b1;
      st |= 1 << b;
    end else if (a) begin
      h = 1'b0;
    end
  endtask
  task automatic trial(input logic [7:0] l, r, a, b, c, f);
    wr(OFS_CONFIG, {24'h0, f});
    sync(13);
    wr(OFS_LOCAL_HIGH, {24'h0, a});
    wr(OFS_REMOTE_HIGH, {24'h0, b});
    wr(OFS_CRIT, {24'h0, c});
    local_temp_reading <= l;
    remote_temp_reading <= r;
    // Last trial's flags, read before the first result of the new values lands
    rd(OFS_STATUS);
    cmp(rdat, st);
    st = 0;
    {al, ar, acl, acr} = {hl, hr, cl, cr};
    repeat (5 * SLOT) @(posedge sys_clk);
    upd(l, a, hl, al, ST_LOCAL_HIGH_BIT);
    upd(r, b, hr, ar, ST_REMOTE_HIGH_BIT);
    upd(l, c, cl, acl, ST_LOCAL_CRIT_BIT);
    upd(r, c, cr, acr, ST_REMOTE_CRIT_BIT);
    cmp(alert_oe, ((hl | hr) & ~f[CFG_ALERT_MASK_BIT]) ^ f[CFG_ALERT_POL_BIT]);
    cmp(critical_alarm_oe, cl | cr);
    rd(OFS_LOCAL_TEMP);
    cmp(rdat, {24'h0, l});
    rd(OFS_REMOTE_TEMP);
    cmp(rdat, {24'h0, r});
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      rd(OFS_LOCAL_HIGH + 6'(4 * i));
      cmp(rdat, {24'h0, SETPOINT_RESET});
    end
    rd(6'h3c);
    cmp(resp, RESP_SLVERR);
    wr(6'h3c, 32'h1);
    cmp(resp, RESP_SLVERR);
    for (int i = 0; i < 5; i++) begin
      trial(tv[i][0], tv[i][1], tv[i][2], tv[i][3], tv[i][4], tv[i][5]);
    end
    for (int i = 0; i < 6; i++) begin
      trial(xs(), xs(), xs(), xs(), xs(), xs() & 8'h82);
    end
    rd(OFS_STATUS);
    cmp(rdat, st);
    u_host.frame(8'ha5);
    rd(OFS_SERIAL);
    cmp(rdat, 32'h1);
    u_host.hold_low(TMO * 16);
    rd(OFS_SERIAL);
    cmp(rdat, 32'h2);
    cmp(irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge sys_clk);
    cmp(irq, 1'b1);
    u_host.idle();
    repeat (6) @(posedge sys_clk);
    rd(OFS_SERIAL);
    cmp(rdat, 32'h0);
    wr(OFS_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge sys_clk);
    cmp(irq, 1'b0);
    give_verdict();
  end
  // Watchdog against a hung handshake
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
